// ### hw/pucms_top.sv
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/1ns
`include "pucms_params.svh"
module pucms_top #(
  parameter int unsigned POR_LONG_CYCLES  = 32'(`PUCMS_POR_LONG_CYC),
  parameter int unsigned POR_SHORT_CYCLES = 32'(`PUCMS_POR_SHORT_CYC)
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        reset_delay_select,
  input  wire logic        preconfig_weak_resistor_off,
  input  wire logic        reconfig_request_low,
  input  wire logic        reconfig_pulse_instruction,
  input  wire logic        config_done,
  output logic             config_enable,
  output logic             user_reset,
  output logic             io_tristate,
  output logic             weak_pullup_en,
  output logic             command_mode,
  output logic             user_mode
);
  import pucms_pkg::*;

  pucms_regs_t r;
  pucms_regs_t n;
  logic        access;
  logic        commit;
  logic        trig;
  logic        por_done;

  // Sequence in brief:
  //   POR    counts the selected delay; pins tri-stated, no command mode
  //   CONFIG waits for the load to finish; pins still tri-stated
  //   INIT   clears user registers, then releases the pins
  //   USER   normal operation; pull-ups handed to user logic
  //   RECFG  holds while a request stands, then reloads from CONFIG
  // Any trigger outside POR lands in RECFG, so a reload always starts
  // from a clean CONFIG entry and never from half-run initialization.
  //
  // Register bus in brief:
  //   access  first access cycle; read data and error are captured
  //   commit  second access cycle, pready high; writes take effect
  // Writes wait for commit so an abandoned transfer changes nothing.

  // Pin synchronisers only read stage 1; stage 0 feeds nothing else
  always_comb begin
    n = r;
    n.sel_sync  = {r.sel_sync[0], reset_delay_select};
    n.pull_sync = {r.pull_sync[0], preconfig_weak_resistor_off};
    n.req_sync  = {r.req_sync[0], reconfig_request_low};
    access   = psel && penable && !r.pready;
    // Completion edge: the master samples pready high here
    commit   = psel && penable && r.pready;
    trig     = !r.req_sync[1] || reconfig_pulse_instruction ||
               r.soft_req;
    por_done = r.sel_sync[1] ?
               (r.por_cnt >= POR_SHORT_CYCLES - 32'd1) :
               (r.por_cnt >= POR_LONG_CYCLES - 32'd1);

    // Sequencer
    unique case (r.state)
      PUCMS_POR: begin
        // Triggers are ignored here; a pin held low is seen in CONFIG
        // Select is read after sync, so the first two cycles count long
        n.por_cnt  = r.por_cnt + 32'd1;
        n.long_por = !r.sel_sync[1];
        if (por_done) begin
          n.state = PUCMS_CONFIG;
        end
      end
      PUCMS_CONFIG: begin
        // A trigger beats a done in the same cycle: reload wins
        if (trig) begin
          n.state = PUCMS_RECFG;
        end else if (config_done) begin
          n.state    = PUCMS_INIT;
          n.init_cnt = 8'h00;
        end
      end
      PUCMS_INIT: begin
        // First half clears registers, second half drives the pins
        n.init_cnt = r.init_cnt + 8'h01;
        if (trig) begin
          n.state = PUCMS_RECFG;
        end else if (r.init_cnt == `PUCMS_INIT_TOTAL_CYC - 8'h01) begin
          n.state = PUCMS_USER;
        end
      end
      PUCMS_USER: begin
        if (trig) begin
          n.state = PUCMS_RECFG;
        end
      end
      PUCMS_RECFG: begin
        // Pin still low holds here; a one-cycle instruction passes through
        if (r.req_sync[1] && !reconfig_pulse_instruction) begin
          n.state = PUCMS_CONFIG;
        end
      end
    endcase

    // Count each entry into reconfiguration
    if (n.state == PUCMS_RECFG && r.state != PUCMS_RECFG) begin
      n.recfg_cnt = r.recfg_cnt + 16'h0001;
      n.soft_req  = 1'b0;
    end

    // Outputs follow the next state so they stay exact to the cycle
    n.config_enable = (n.state == PUCMS_CONFIG);
    n.user_mode     = (n.state == PUCMS_USER);
    n.command_mode  = (n.state != PUCMS_USER) &&
                      (n.state != PUCMS_POR);
    n.user_reset    = (n.state == PUCMS_INIT) &&
                      (n.init_cnt < `PUCMS_INIT_RESET_CYC);
    n.io_tristate   = !((n.state == PUCMS_USER) ||
                        ((n.state == PUCMS_INIT) &&
                         (n.init_cnt >= `PUCMS_INIT_RESET_CYC)));
    // User logic owns pull-ups once running, so they drop in user mode
    n.pullup_en     = (n.state != PUCMS_USER) &&
                      !r.pull_sync[1];

    // APB slave: one wait state, answer in the second access cycle
    n.pready  = access;
    n.pslverr = 1'b0;
    n.prdata  = 32'h0000_0000;
    if (access) begin
      unique case (paddr)
        `PUCMS_ADDR_CTRL: begin
          n.prdata[`PUCMS_CTRL_SOFT_RECFG] = r.soft_req;
        end
        `PUCMS_ADDR_STATUS: begin
          n.prdata[`PUCMS_ST_USER]     = r.user_mode;
          n.prdata[`PUCMS_ST_COMMAND]  = r.command_mode;
          n.prdata[`PUCMS_ST_TRISTATE] = r.io_tristate;
          n.prdata[`PUCMS_ST_PULLUP]   = r.pullup_en;
          n.prdata[`PUCMS_ST_LONG_POR] = r.long_por;
          n.prdata[`PUCMS_ST_STATE_LSB +: 3] = r.state;
        end
        `PUCMS_ADDR_RECFG_CNT: begin
          n.prdata[15:0] = r.recfg_cnt;
        end
        default: begin
          n.pslverr = 1'b1;
        end
      endcase
    end

    // Write lands at the edge where pready is seen high, not before
    // Set wins over the clear on entry to reconfiguration
    if (commit && pwrite && (paddr == `PUCMS_ADDR_CTRL) &&
        pwdata[`PUCMS_CTRL_SOFT_RECFG]) begin
      n.soft_req = 1'b1;
    end
  end

  // Reset puts I/O in high impedance and pull-ups on until the pin is seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r               <= '0;
      r.state         <= PUCMS_POR;
      r.por_cnt       <= `PUCMS_RST_POR_CNT;
      r.recfg_cnt     <= `PUCMS_RST_RECFG_CNT;
      r.sel_sync      <= 2'h0;
      r.pull_sync     <= 2'h0;
      r.req_sync      <= 2'h3;
      r.long_por      <= 1'b1;
      r.io_tristate   <= 1'b1;
      r.pullup_en     <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign prdata         = r.prdata;
  assign pready         = r.pready;
  assign pslverr        = r.pslverr;
  assign config_enable  = r.config_enable;
  assign user_reset     = r.user_reset;
  assign io_tristate    = r.io_tristate;
  assign weak_pullup_en = r.pullup_en;
  assign command_mode   = r.command_mode;
  assign user_mode      = r.user_mode;
endmodule

// ### hw/pucms_params.svh
`ifndef PUCMS_PARAMS_SVH
`define PUCMS_PARAMS_SVH

// Clock rate
`define PUCMS_CLK_HZ          100000000

// Power-on reset delays, in milliseconds
`define PUCMS_POR_LONG_MS     100
`define PUCMS_POR_SHORT_MS    12
`define PUCMS_POR_LONG_CYC    (64'd`PUCMS_POR_LONG_MS * 64'd`PUCMS_CLK_HZ / 64'd1000)
`define PUCMS_POR_SHORT_CYC   (64'd`PUCMS_POR_SHORT_MS * 64'd`PUCMS_CLK_HZ / 64'd1000)

// Initialization phase: register reset cycles, then total cycles
`define PUCMS_INIT_RESET_CYC  8'h04
`define PUCMS_INIT_TOTAL_CYC  8'h08

// Register byte offsets
`define PUCMS_ADDR_CTRL       12'h000
`define PUCMS_ADDR_STATUS     12'h004
`define PUCMS_ADDR_RECFG_CNT  12'h008

// Field positions
`define PUCMS_CTRL_SOFT_RECFG 0
`define PUCMS_ST_USER         0
`define PUCMS_ST_COMMAND      1
`define PUCMS_ST_TRISTATE     2
`define PUCMS_ST_PULLUP       3
`define PUCMS_ST_LONG_POR     4
`define PUCMS_ST_STATE_LSB    8

// Reset values
`define PUCMS_RST_RECFG_CNT   16'h0000
`define PUCMS_RST_POR_CNT     32'h0000_0000

`endif

// ### hw/pucms_pkg.sv
package pucms_pkg;
  typedef enum logic [2:0] {
    PUCMS_POR,
    PUCMS_CONFIG,
    PUCMS_INIT,
    PUCMS_USER,
    PUCMS_RECFG
  } pucms_state_t;

  typedef struct packed {
    pucms_state_t state;
    logic [31:0]  por_cnt;
    logic [7:0]   init_cnt;
    logic [1:0]   sel_sync;
    logic [1:0]   pull_sync;
    logic [1:0]   req_sync;
    logic         long_por;
    logic         soft_req;
    logic [15:0]  recfg_cnt;
    logic         user_mode;
    logic         command_mode;
    logic         io_tristate;
    logic         pullup_en;
    logic         user_reset;
    logic         config_enable;
    logic         pready;
    logic         pslverr;
    logic [31:0]  prdata;
  } pucms_regs_t;
endpackage

// ### dv/pucms_sva.sv
`timescale 1ns/1ns
module pucms_sva (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pready,
  input logic preconfig_weak_resistor_off,
  input logic reconfig_request_low,
  input logic reconfig_pulse_instruction,
  input logic config_enable,
  input logic user_reset,
  input logic io_tristate,
  input logic weak_pullup_en,
  input logic command_mode,
  input logic user_mode
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Init steps; a trigger inside init would cut them short
  sequence s_clear; user_reset [*4]; endsequence
  sequence s_io_on; (!user_reset && !io_tristate) [*4]; endsequence
  a_init_order: assert property ($rose(user_reset) |->
    s_clear ##1 s_io_on ##1 user_mode) else $error("init order");
  a_mode_excl: assert property (!(user_mode && command_mode))
    else $error("both modes");
  a_user_pins: assert property (user_mode |->
    !io_tristate && !weak_pullup_en) else $error("user pins");
  a_cfg_hold: assert property (config_enable |->
    io_tristate && command_mode && !user_mode) else $error("cfg pins");
  a_pull_sel: assert property (command_mode |->
    weak_pullup_en != preconfig_weak_resistor_off) else $error("pull");
  a_pulse_exit: assert property (reconfig_pulse_instruction &&
    user_mode |=> command_mode && io_tristate ##1 config_enable)
    else $error("pulse exit");
  a_pin_exit: assert property ($fell(reconfig_request_low) &&
    user_mode |-> ##[1:4] command_mode) else $error("pin exit");
  a_apb_answer: assert property (psel && penable && !pready |=> pready)
    else $error("no pready");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
endmodule

// ### dv/pucms_cfg_src.sv
`timescale 1ns/1ns
module pucms_cfg_src (
  input  logic       pclk,
  input  logic       presetn,
  input  logic       config_enable,
  input  logic [7:0] load_cycles,
  output logic       config_done
);
  logic [7:0] cnt_r;
  // Count the load; restart on every new enable so reloads are fresh
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_r <= 8'h00;
    else cnt_r <= config_enable ? cnt_r + 8'h01 : 8'h00;
  end
  // Done drops with enable: a stale level must not end a reload
  assign config_done = config_enable && cnt_r >= load_cycles;
endmodule

// ### dv/pucms_top_tb.sv
`timescale 1ns/1ns
module pucms_top_tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, config_done, config_enable;
  logic        reset_delay_select = 0, preconfig_weak_resistor_off = 0;
  logic        reconfig_request_low = 1, reconfig_pulse_instruction = 0;
  logic        user_reset, io_tristate, weak_pullup_en, command_mode;
  logic        user_mode;
  logic [7:0]  load_cycles = 8'h14;
  int          failures = 0, check_count = 0, n;
  typedef struct packed {
    logic w; logic [11:0] a; logic [31:0] d; logic [31:0] r; logic e;
  } pucms_row_t;
  // Status in user mode, read-only write, count, ctrl, unmapped
  pucms_row_t rows [6] = '{'{0, 12'h004, 0, 32'h311, 0},
    '{1, 12'h004, 32'hffff_ffff, 0, 0}, '{0, 12'h004, 0, 32'h311, 0},
    '{0, 12'h008, 0, 0, 0}, '{0, 12'h000, 0, 0, 0},
    '{0, 12'h00c, 0, 0, 1}};
  pucms_top #(.POR_LONG_CYCLES(40), .POR_SHORT_CYCLES(12)) pucms_top_i (.*);
  pucms_cfg_src pucms_cfg_src_i (.*);
  always #5 pclk = ~pclk;
  // Watchdog; the longest path is a few hundred cycles
  initial begin
    #20000;
    failures++;
    final_report();
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) failures++;
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  // Trigger takes a few cycles to leave user mode
  task automatic wait_user();
    repeat (3) @(posedge pclk);
    n = 0;
    while (user_mode !== 1'h1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    chk(user_mode, 1);
  endtask
  task automatic por(input logic s, input logic p, input int x);
    presetn <= 0;
    reset_delay_select <= s;
    preconfig_weak_resistor_off <= p;
    repeat (2) @(posedge pclk);
    chk({io_tristate, weak_pullup_en, user_mode}, 3'h6);
    presetn <= 1;
    n = 0;
    while (config_enable !== 1'h1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    chk(n + 1 >= x && n <= x + 4, 1);
    chk({command_mode, io_tristate, user_mode, weak_pullup_en}, {3'h6, !p});
    wait_user();
  endtask
  task automatic final_report();
    $display("TB: %0d failures, %0d checks", failures, check_count);
    if (failures == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    por(0, 0, 40);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk(err, rows[i].e);
      if (!rows[i].w) chk(rd, rows[i].r);
    end
    apb(1, 12'h000, 1);
    wait_user();
    load_cycles <= 8'h00;
    reconfig_pulse_instruction <= 1;
    @(posedge pclk);
    reconfig_pulse_instruction <= 0;
    @(posedge pclk);
    chk({command_mode, user_mode}, 2'h2);
    wait_user();
    reconfig_request_low <= 0;
    repeat (6) @(posedge pclk);
    chk({command_mode, config_enable}, 2'h2);
    reconfig_request_low <= 1;
    wait_user();
    apb(0, 12'h008, 0);
    chk(rd, 32'h3);
    por(1, 1, 12);
    apb(0, 12'h004, 0);
    chk(rd, 32'h301);
    final_report();
  end
endmodule
bind pucms_top pucms_sva pucms_sva_i (.*);
